/* shared/nbmo_pkg.sv */
// Package with opcodes, widths and reset values for the misc-ops decoder
package nbmo_pkg;
  localparam int INSN_W = 10;
  localparam int ACC_W = 4;
  localparam int RAM_AW = 7;
  // Opcode encodings; a real core will supply its own
  localparam logic [9:0] OP_NOP = 10'h000;
  localparam logic [9:0] OP_POWER_OFF = 10'h002;
  localparam logic [9:0] OP_POWER_OFF_ENABLE = 10'h2B1;
  localparam logic [9:0] OP_ROTATE_RIGHT = 10'h01D;
  localparam logic [9:0] OP_BIT_CLEAR_BASE = 10'h04C;
  localparam logic [9:0] OP_BIT_CLEAR_MASK = 10'h3FC;
  localparam logic [9:0] OP_PAGE_BANK_CLEAR = 10'h270;
  localparam logic [9:0] OP_PAGE_BANK_SET = 10'h27F;
  localparam int BITSEL_POS = 0;
  localparam logic [ACC_W-1:0] ACC_RESET = 4'h0;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic BANK_RESET = 1'b0;
  localparam int PAGE_BIT = 6;
  typedef enum logic [1:0] {NBMO_RUN, NBMO_BACKUP} nbmo_state_t;
endpackage

/* hdl/nbmo_bit_clear.sv */
// Nibble bit-clear datapath for data memory writeback
`timescale 1ns/1ps
module nbmo_bit_clear #(
  parameter int W = 4
) (
  // Data in
  input wire logic [W-1:0] nib,
  input wire logic [1:0] sel,
  // Data out
  output logic [W-1:0] res
);
  // Two select bits reach four nibble bits only
  if (W != 4) begin
    $error("nbmo_bit_clear supports only 4-bit nibbles");
  end
  always_comb begin
    res = nib;
    res[sel] = 1'b0; // RL4
  end
endmodule

/* hdl/nbmo_misc_ops.sv */
// Decoder and executor for power-off, rotate, bit-clear and bank-clear ops
`timescale 1ns/1ps
// Operation
// RL1: Enable then power-off enters RAM back-up
// RL2: Power-off without enable acts as no-op
// RL3: Rotate right through carry as ring
// RL4: Bit-clear zeroes selected nibble bit at pointer
// RL5: Bank clear forces table page bit six low
// RL6: One word, one cycle, never skips
module nbmo_misc_ops #(
  parameter int PC_W = 14
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction issue, one word per instruction cycle
  input wire logic insn_valid,
  input wire logic [nbmo_pkg::INSN_W-1:0] insn,
  // Accumulator result of words executed outside this block
  input wire logic acc_load,
  input wire logic [nbmo_pkg::ACC_W-1:0] acc_load_data,
  input wire logic carry_load_data,
  // Data memory nibble at the data pointer
  input wire logic [nbmo_pkg::RAM_AW-1:0] data_pointer,
  input wire logic [nbmo_pkg::ACC_W-1:0] mem_rdata,
  // Table lookup page request
  input wire logic [6:0] table_page_in,
  // Wakeup pin, asynchronous to mclk
  input wire logic wake,
  // Architectural state
  output logic [nbmo_pkg::ACC_W-1:0] acc,
  output logic carry_flag,
  output logic [PC_W-1:0] pc,
  // Data memory write
  output logic mem_we,
  output logic [nbmo_pkg::RAM_AW-1:0] mem_waddr,
  output logic [nbmo_pkg::ACC_W-1:0] mem_wdata,
  // Status
  output logic bank_flag,
  output logic [6:0] table_page,
  output logic backup,
  output logic skip_next
);
  import nbmo_pkg::*;

  // Refuse counter widths the sequencer cannot serve
  if (PC_W < 1 || PC_W > 16) begin
    $error("PC_W out of range");
  end

  // Wakeup synchroniser
  logic wake_s1_reg, wake_s1_next;
  logic wake_s2_reg, wake_s2_next;
  logic wake_s3_reg, wake_s3_next;
  logic wake_q_reg, wake_q_next;

  // Sequencer
  nbmo_state_t state_reg, state_next;
  logic [PC_W-1:0] pc_reg, pc_next;
  logic enable_seen_reg, enable_seen_next;
  logic backup_reg, backup_next;
  logic skip_flag_reg, skip_flag_next;

  // Accumulator and carry
  logic [ACC_W-1:0] acc_reg, acc_next;
  logic carry_reg, carry_next;

  // Data memory write
  logic we_reg, we_next;
  logic [RAM_AW-1:0] waddr_reg, waddr_next;
  logic [ACC_W-1:0] wdata_reg, wdata_next;

  // Bank flag and table page
  logic bank_reg, bank_next;
  logic [6:0] page_reg, page_next;

  // Decode
  logic exec;
  logic op_pof, op_pof_en, op_rot, op_bitclr, op_bclr, op_bset;
  logic own_op;
  logic [ACC_W-1:0] cleared;

  assign exec = insn_valid && (state_reg == NBMO_RUN);
  assign op_pof = (insn == OP_POWER_OFF);
  assign op_pof_en = (insn == OP_POWER_OFF_ENABLE);
  assign op_rot = (insn == OP_ROTATE_RIGHT);
  assign op_bitclr = (insn & OP_BIT_CLEAR_MASK) == OP_BIT_CLEAR_BASE;
  assign op_bclr = (insn == OP_PAGE_BANK_CLEAR);
  assign op_bset = (insn == OP_PAGE_BANK_SET);
  // Words decoded here never take an outside accumulator result
  assign own_op = op_pof | op_pof_en | op_rot | op_bitclr | op_bclr | op_bset;

  nbmo_bit_clear #(
    .W(ACC_W)
  ) u_clr (
    .nib(mem_rdata),
    .sel(insn[BITSEL_POS +: 2]),
    .res(cleared)
  );

  always_comb begin
    wake_s1_next = wake;
    wake_s2_next = wake_s1_reg;
    wake_s3_next = wake_s2_reg;
    wake_q_next = wake_q_reg;
    // Pin level counts only once two stages agree
    if (wake_s2_reg == wake_s3_reg) begin
      wake_q_next = wake_s3_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_s3_reg <= 1'b0;
      wake_q_reg <= 1'b0;
    end else begin
      wake_s1_reg <= wake_s1_next;
      wake_s2_reg <= wake_s2_next;
      wake_s3_reg <= wake_s3_next;
      wake_q_reg <= wake_q_next;
    end
  end

  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    enable_seen_next = enable_seen_reg;
    case (state_reg)
      NBMO_RUN: begin
        if (insn_valid) begin
          pc_next = pc_reg + 1'b1; // RL6
          // Enable arms only the very next executed word
          enable_seen_next = op_pof_en; // RL2
          // Unarmed power-off falls through as a plain no-op
          if (op_pof && enable_seen_reg) begin
            state_next = NBMO_BACKUP; // RL1
          end
        end
      end
      NBMO_BACKUP: begin
        // Words refused and memory held until wakeup
        if (wake_q_reg) begin
          state_next = NBMO_RUN;
        end
      end
      default: begin
        state_next = NBMO_RUN;
      end
    endcase
    backup_next = (state_next == NBMO_BACKUP); // RL1
    // These words never skip the one that follows
    skip_flag_next = 1'b0; // RL6
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= NBMO_RUN;
      pc_reg <= '0;
      enable_seen_reg <= 1'b0;
      backup_reg <= 1'b0;
      skip_flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      enable_seen_reg <= enable_seen_next;
      backup_reg <= backup_next;
      skip_flag_reg <= skip_flag_next;
    end
  end

  always_comb begin
    acc_next = acc_reg;
    carry_next = carry_reg;
    if (exec) begin
      if (op_rot) begin
        // Carry and accumulator turn as one five-bit ring
        acc_next = {carry_reg, acc_reg[ACC_W-1:1]}; // RL3
        carry_next = acc_reg[0]; // RL3
      end else if (acc_load && !own_op) begin // RL2
        acc_next = acc_load_data;
        carry_next = carry_load_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_reg <= ACC_RESET;
      carry_reg <= CARRY_RESET;
    end else begin
      acc_reg <= acc_next;
      carry_reg <= carry_next;
    end
  end

  always_comb begin
    we_next = 1'b0;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    if (exec && op_bitclr) begin
      we_next = 1'b1; // RL4
      waddr_next = data_pointer; // RL4
      wdata_next = cleared; // RL4
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      we_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      we_reg <= we_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end

  always_comb begin
    bank_next = bank_reg;
    page_next = page_reg;
    if (exec) begin
      if (op_bclr) begin
        bank_next = 1'b0; // RL5
      end else if (op_bset) begin
        bank_next = 1'b1;
      end
      // Lookup sees the flag as it stood before this word
      page_next = table_page_in;
      page_next[PAGE_BIT] = table_page_in[PAGE_BIT] & bank_reg; // RL5
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      bank_reg <= BANK_RESET;
      page_reg <= '0;
    end else begin
      bank_reg <= bank_next;
      page_reg <= page_next;
    end
  end

  assign acc = acc_reg;
  assign carry_flag = carry_reg;
  assign pc = pc_reg;
  assign mem_we = we_reg;
  assign mem_waddr = waddr_reg;
  assign mem_wdata = wdata_reg;
  assign bank_flag = bank_reg;
  assign table_page = page_reg;
  assign backup = backup_reg; // RL1
  assign skip_next = skip_flag_reg; // RL6
endmodule

/* test/nbmo_checker.sv */
// Port checker for the misc-ops decoder
`timescale 1ns/1ps
module nbmo_checker
  import nbmo_pkg::*;
#(parameter int PC_W = 14) (
  input wire logic mclk, rst, insn_valid, wake,
  input wire logic [9:0] insn,
  input wire logic [6:0] data_pointer, mem_waddr, table_page,
  input wire logic [3:0] mem_rdata, acc, mem_wdata,
  input wire logic carry_flag, mem_we, bank_flag, backup, skip_next,
  input wire logic [PC_W-1:0] pc
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic x, en_reg;
  assign x = insn_valid && !backup;
  // Last executed word was the enable
  always_ff @(posedge mclk) begin
    if (rst) en_reg <= 1'b0;
    else if (x) en_reg <= (insn == OP_POWER_OFF_ENABLE);
  end
  property p_pof; x && insn == OP_POWER_OFF && en_reg |=> backup; endproperty
  a_pof: assert property (p_pof) else $error("no back-up");
  property p_nop;
    x && insn == OP_POWER_OFF && !en_reg |=> !backup && $stable(acc) && !mem_we;
  endproperty
  a_nop: assert property (p_nop) else $error("bad no-op");
  property p_rot;
    x && insn == OP_ROTATE_RIGHT |=> {acc, carry_flag} == $past({carry_flag, acc});
  endproperty
  a_rot: assert property (p_rot) else $error("bad rotate");
  property p_clr;
    x && (insn & OP_BIT_CLEAR_MASK) == OP_BIT_CLEAR_BASE |=> mem_we
      && mem_waddr == $past(data_pointer)
      && mem_wdata == ($past(mem_rdata) & ~(4'h1 << $past(insn[1:0])));
  endproperty
  a_clr: assert property (p_clr) else $error("bad clear");
  property p_bank; x && insn == OP_PAGE_BANK_CLEAR |=> !bank_flag; endproperty
  a_bank: assert property (p_bank) else $error("flag set");
  property p_page; x && !bank_flag |=> !table_page[6]; endproperty
  a_page: assert property (p_page) else $error("page bit high");
  property p_pc; x |=> pc == $past(pc) + 1'b1 && !skip_next; endproperty
  a_pc: assert property (p_pc) else $error("bad step");
  c_rot: cover property (x && insn == OP_ROTATE_RIGHT);
  c_pof: cover property (x && insn == OP_POWER_OFF && en_reg);
  c_clr: cover property (mem_we);
endmodule
bind nbmo_misc_ops nbmo_checker #(
  .PC_W(PC_W)
) chk (
  .mclk(mclk),
  .rst(rst),
  .insn_valid(insn_valid),
  .wake(wake),
  .insn(insn),
  .data_pointer(data_pointer),
  .mem_waddr(mem_waddr),
  .table_page(table_page),
  .mem_rdata(mem_rdata),
  .acc(acc),
  .mem_wdata(mem_wdata),
  .carry_flag(carry_flag),
  .mem_we(mem_we),
  .bank_flag(bank_flag),
  .backup(backup),
  .skip_next(skip_next),
  .pc(pc)
);

/* test/test_nibble_cpu_misc_ops.sv */
// Random and corner bench for the misc-ops decoder
`timescale 1ns/1ps
module test_nibble_cpu_misc_ops;
  import nbmo_pkg::*;
  logic mclk = 0, rst = 1, insn_valid = 0, wake = 0;
  logic [9:0] insn = 10'h000;
  logic [6:0] data_pointer = 7'h00, table_page_in = 7'h00, mem_waddr, table_page;
  logic [3:0] acc, mem_rdata = 4'h0, mem_wdata;
  logic carry_flag, mem_we, bank_flag, backup, skip_next;
  logic acc_load = 0, carry_load_data = 0;
  logic [3:0] acc_load_data = 4'h0;
  logic [4:0] ring;
  logic [13:0] pc, pc_exp;
  logic [1:0] j;
  int errors = 0, comparisons = 0, cyc = 0;
  always #10 mclk = ~mclk;
  nbmo_misc_ops dut (
    .mclk(mclk),
    .rst(rst),
    .insn_valid(insn_valid),
    .insn(insn),
    .acc_load(acc_load),
    .acc_load_data(acc_load_data),
    .carry_load_data(carry_load_data),
    .data_pointer(data_pointer),
    .mem_rdata(mem_rdata),
    .table_page_in(table_page_in),
    .wake(wake),
    .acc(acc),
    .carry_flag(carry_flag),
    .pc(pc),
    .mem_we(mem_we),
    .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata),
    .bank_flag(bank_flag),
    .table_page(table_page),
    .backup(backup),
    .skip_next(skip_next)
  );
  function automatic logic [3:0] clr(logic [3:0] d, logic [1:0] b);
    return d & ~(4'h1 << b);
  endfunction
  // Ring of accumulator and carry turned one place right
  function automatic logic [4:0] ror(logic [4:0] r);
    return {r[0], r[4:1]};
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Page bit six always asked for, so only the flag can drop it
  task automatic step(logic [9:0] i, logic v);
    @(negedge mclk);
    insn_valid = v;
    insn = i;
    data_pointer = 7'($urandom);
    mem_rdata = 4'($urandom);
    table_page_in = {1'b1, 6'($urandom)};
    // Outside result offered on a random half of the words; only foreign words take it
    acc_load = 1'($urandom);
    acc_load_data = 4'($urandom);
    carry_load_data = 1'($urandom);
    if (v && !backup) pc_exp++;
    @(posedge mclk);
    #1;
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) if (++cyc > 3000) begin
    errors++;
    complete_run;
  end
  initial begin
    void'($urandom(32'hF2C4B78F));
    repeat (16) @(negedge mclk);
    rst = 0;
    pc_exp = 14'h0000;
    step(OP_POWER_OFF, 1);
    chk(backup, 1'b0);
    chk(pc, pc_exp);
    // Enable then an unrelated word disarms power-off
    step(OP_POWER_OFF_ENABLE, 1);
    step(OP_NOP, 1);
    ring = {acc, carry_flag};
    step(OP_POWER_OFF, 1);
    chk(backup, 1'b0);
    chk({acc, carry_flag}, ring);
    repeat (8) begin
      step(OP_NOP, 1);
      ring = {acc, carry_flag};
      step(OP_ROTATE_RIGHT, 1);
      chk({acc, carry_flag}, ror(ring));
    end
    step(OP_PAGE_BANK_SET, 1);
    step(OP_NOP, 1);
    chk(table_page[6], 1'b1);
    step(OP_PAGE_BANK_CLEAR, 1);
    chk(bank_flag, 1'b0);
    step(OP_NOP, 1);
    chk(table_page[6], 1'b0);
    repeat (40) begin
      j = 2'($urandom);
      step(OP_BIT_CLEAR_BASE | 10'(j), 1'($urandom));
      chk(mem_we, insn_valid);
      if (insn_valid) chk(mem_wdata, clr(mem_rdata, j));
      if (insn_valid) chk(mem_waddr, data_pointer);
      chk(pc, pc_exp);
    end
    step(OP_POWER_OFF_ENABLE, 1);
    step(OP_POWER_OFF, 1);
    chk(backup, 1'b1);
    ring = {acc, carry_flag};
    step(OP_ROTATE_RIGHT, 1);
    chk(pc, pc_exp);
    chk({acc, carry_flag}, ring);
    @(negedge mclk);
    insn_valid = 0;
    wake = 1;
    // Pin passes a three-stage synchroniser before it counts
    repeat (8) if (backup) @(negedge mclk);
    wake = 0;
    chk(backup, 1'b0);
    step(OP_NOP, 1);
    chk(pc, pc_exp);
    complete_run;
  end
endmodule
